// ===== core/dcr_ahb_slave.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"

module dcr_ahb_slave (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // AHB-Lite slave side
  input  wire logic              hsel,
  input  wire dcr_pkg::dcr_addr_t haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire dcr_pkg::dcr_word_t hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output dcr_pkg::dcr_word_t     hrdata,
  // Register side
  input  wire dcr_pkg::dcr_word_t rdData,
  output logic                   wrStb,
  output dcr_pkg::dcr_addr_t     wrAddr,
  output dcr_pkg::dcr_word_t     wrData
);
  import dcr_pkg::*;

  logic      accept;      // Address phase taken
  logic      wrPend_r;    // Write data phase pending
  logic      wrPend_nxt;
  dcr_addr_t wrAddr_r;    // Latched write address
  dcr_addr_t wrAddr_nxt;
  dcr_word_t hrdata_r;    // Read data for data phase
  dcr_word_t hrdata_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Address phase decode and next state
  always_comb begin
    accept     = hsel & htrans[`DCR_HTRANS_ACT_BIT] & hready;
    wrPend_nxt = accept & hwrite & (hsize == `DCR_HSIZE_WORD);
    wrAddr_nxt = accept ? haddr : wrAddr_r;
    hrdata_nxt = (accept & ~hwrite) ? rdData : hrdata_r;
  end

  // Phase registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      hrdata_r <= `DCR_WORD_ZERO;
    end else begin
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero wait state, always OKAY
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= `DCR_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `DCR_HRESP_OKAY;
    end
  end

  // Register side outputs
  assign hrdata = hrdata_r;
  assign wrStb  = wrPend_r;
  assign wrAddr = wrAddr_r;
  assign wrData = hwdata;

endmodule // dcr_ahb_slave

// ===== core/dcr_cfg.svh
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH

////////////////////////////////////////////////////////////////////////
// Register byte offsets (low address bits only)
`define DCR_ADDR_W        12
`define DCR_CAPS_OFFS     12'h0E4
`define DCR_CTRL_OFFS     12'h100
`define DCR_STAT_OFFS     12'h104

////////////////////////////////////////////////////////////////////////
// Capability word field positions
`define DCR_PAYLOAD_MSB   2
`define DCR_PAYLOAD_LSB   0
`define DCR_PHANTOM_MSB   4
`define DCR_PHANTOM_LSB   3
`define DCR_EXTTAG_BIT    5
`define DCR_L0S_MSB       8
`define DCR_L0S_LSB       6
`define DCR_L1_MSB        11
`define DCR_L1_LSB        9
`define DCR_ATTBTN_BIT    12
`define DCR_PWRIND_BIT    14
`define DCR_ROLEERR_BIT   15
`define DCR_SPLV_MSB      25
`define DCR_SPLV_LSB      18
`define DCR_SPLS_MSB      27
`define DCR_SPLS_LSB      26

////////////////////////////////////////////////////////////////////////
// Reset values of the configurable fields
`define DCR_PAYLOAD_RST   3'h1
`define DCR_L0S_RST       3'h0
`define DCR_L1_RST        3'h0
`define DCR_ROLEERR_RST   1'h1
`define DCR_SPLV_RST      8'h00
`define DCR_SPLS_RST      2'h0

////////////////////////////////////////////////////////////////////////
// Control and status bits
`define DCR_CTRL_CAPEN_BIT  0
`define DCR_CTRL_CAPEN_RST  1'h1
`define DCR_STAT_SB_BIT     0
`define DCR_STAT_MSG_BIT    1
`define DCR_STAT_RST        2'h0

////////////////////////////////////////////////////////////////////////
// AHB-Lite codes
`define DCR_HTRANS_ACT_BIT  1
`define DCR_HSIZE_WORD      3'h2
`define DCR_HRESP_OKAY      1'h0
`define DCR_WORD_ZERO       32'h0000_0000

`endif

// ===== core/dcr_device_caps.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"

module dcr_device_caps (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // AHB-Lite register bus
  input  wire logic               hsel,
  input  wire dcr_pkg::dcr_addr_t haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire dcr_pkg::dcr_word_t hwdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output dcr_pkg::dcr_word_t      hrdata,
  // Sideband default loader
  input  wire logic               sbLoad,
  input  wire dcr_pkg::dcr_word_t sbWord,
  // Slot power limit message
  input  wire logic               splMsgValid,
  input  wire logic [7:0]         splMsgValue,
  input  wire logic [1:0]         splMsgScale,
  // Capability word to the core
  output dcr_pkg::dcr_word_t      capsWord
);
  import dcr_pkg::*;

  // Limitations:
  // - The capability word has no write path; writes to it
  //   finish with OKAY and change nothing.
  // - Software can gate message capture off; a gated
  //   message leaves no trace, not even in the status.
  // - A sideband load rewrites the slot power fields too,
  //   so it erases a limit captured earlier.
  // - Non-word writes are dropped; reads of any size
  //   return the whole word.

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus side strobes
  logic      wrStb;        // Write data phase
  dcr_addr_t wrAddr;       // Write address
  dcr_word_t wrData;       // Write data
  dcr_word_t rdData;       // Read mux result

  // Capability fields
  dcr_caps_s caps_r;       // Current fields
  dcr_caps_s caps_nxt;     // Next fields

  // Own control register
  logic      capEn_r;      // Message capture enabled
  logic      capEn_nxt;

  // Own sticky status
  logic [1:0] stat_r;      // Load and message seen
  logic [1:0] stat_nxt;
  logic [1:0] statSet;     // Hardware set terms
  logic [1:0] statClr;     // Software clear terms

  // Registered capability word
  dcr_word_t capsWord_r;
  dcr_word_t capsWord_nxt;

  // Write decode
  logic      ctrlWr;       // Write to control
  logic      statWr;       // Write to status
  logic      capture;      // Message is taken

  // Read decode
  logic      capsHit;      // Read of capability word
  logic      ctrlHit;      // Read of control
  logic      statHit;      // Read of status

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Build the full word from the fields
  // Fixed-zero bits are never stored, so nothing can set them
  function automatic dcr_word_t packCaps(input dcr_caps_s c);
    dcr_word_t w;
    // Everything else stays zero
    w = `DCR_WORD_ZERO;
    w[`DCR_PAYLOAD_MSB:`DCR_PAYLOAD_LSB] = c.payload;
    w[`DCR_L0S_MSB:`DCR_L0S_LSB]         = c.l0sLat;
    w[`DCR_L1_MSB:`DCR_L1_LSB]           = c.l1Lat;
    w[`DCR_ROLEERR_BIT]                  = c.roleErr;
    w[`DCR_SPLV_MSB:`DCR_SPLV_LSB]       = c.slotValue;
    w[`DCR_SPLS_MSB:`DCR_SPLS_LSB]       = c.slotScale;
    return w;
  endfunction

  // Pick the fields out of a loaded word
  // Bits outside the configurable fields are dropped here
  function automatic dcr_caps_s unpackCaps(input dcr_word_t w);
    dcr_caps_s c;
    c.payload   = w[`DCR_PAYLOAD_MSB:`DCR_PAYLOAD_LSB];
    c.l0sLat    = w[`DCR_L0S_MSB:`DCR_L0S_LSB];
    c.l1Lat     = w[`DCR_L1_MSB:`DCR_L1_LSB];
    c.roleErr   = w[`DCR_ROLEERR_BIT];
    c.slotValue = w[`DCR_SPLV_MSB:`DCR_SPLV_LSB];
    c.slotScale = w[`DCR_SPLS_MSB:`DCR_SPLS_LSB];
    return c;
  endfunction

  // Reset image of the fields
  // Shared by the field register and the output register
  function automatic dcr_caps_s resetCaps();
    dcr_caps_s c;
    c.payload   = `DCR_PAYLOAD_RST;
    c.l0sLat    = `DCR_L0S_RST;
    c.l1Lat     = `DCR_L1_RST;
    c.roleErr   = `DCR_ROLEERR_RST;
    c.slotValue = `DCR_SPLV_RST;
    c.slotScale = `DCR_SPLS_RST;
    return c;
  endfunction

  // Address match on the word address
  // Byte lanes are ignored, so a sub-word address hits the word
  // The port carries only the low address bits
  function automatic logic hitAddr(input dcr_addr_t a,
                                   input dcr_addr_t offs);
    return a[11:2] == offs[11:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  // Zero wait states; hready comes back from hreadyout outside,
  // so the slave never stalls the bus
  dcr_ahb_slave u_bus (
    .core_clk  (core_clk),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rdData    (rdData),
    .wrStb     (wrStb),
    .wrAddr    (wrAddr),
    .wrData    (wrData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    // Only the control and status words take writes
    // Capability word has no write path
    ctrlWr = wrStb & hitAddr(wrAddr, `DCR_CTRL_OFFS);
    statWr = wrStb & hitAddr(wrAddr, `DCR_STAT_OFFS);
    // Message only counts while enabled
    capture = splMsgValid & capEn_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Capability fields next value
  // No bus write reaches these fields
  always_comb begin
    caps_nxt = caps_r;
    // Sideband or autoloader replaces the defaults
    if (sbLoad) begin
      caps_nxt = unpackCaps(sbWord);
    end
    // Live message overrides a same-cycle load: the message
    // is the newer word on slot power, the load only a default
    if (capture) begin
      caps_nxt.slotValue = splMsgValue;
      caps_nxt.slotScale = splMsgScale;
    end
  end

  // Capability fields register
  // Reset brings back the built-in defaults
  always_ff @(posedge core_clk) begin
    if (reset) begin
      caps_r <= resetCaps();
    end else begin
      caps_r <= caps_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register next value
  // Gates message capture only; loads are never blocked
  always_comb begin
    capEn_nxt = capEn_r;
    // Software enables or blocks capture
    if (ctrlWr) begin
      capEn_nxt = wrData[`DCR_CTRL_CAPEN_BIT];
    end
  end

  // Control register
  // Reset value one keeps plain capture as the default
  always_ff @(posedge core_clk) begin
    if (reset) begin
      capEn_r <= `DCR_CTRL_CAPEN_RST;
    end else begin
      capEn_r <= capEn_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status next value
  always_comb begin
    statSet = 2'h0;
    statClr = 2'h0;
    // Events that set a bit
    statSet[`DCR_STAT_SB_BIT]  = sbLoad;
    statSet[`DCR_STAT_MSG_BIT] = capture;
    // Write one to clear
    if (statWr) begin
      statClr[`DCR_STAT_SB_BIT]  = wrData[`DCR_STAT_SB_BIT];
      statClr[`DCR_STAT_MSG_BIT] = wrData[`DCR_STAT_MSG_BIT];
    end
    // Set wins over clear, so an event is never lost
    // to a clear that meets it in the same cycle
    stat_nxt = (stat_r & ~statClr) | statSet;
  end

  // Sticky status register
  // Cleared only by reset or a write of one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_r <= `DCR_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read address decode
  // Decoded in the address phase, because the slave
  // registers the read data at the edge that takes it
  always_comb begin
    capsHit = hitAddr(haddr, `DCR_CAPS_OFFS);
    ctrlHit = hitAddr(haddr, `DCR_CTRL_OFFS);
    statHit = hitAddr(haddr, `DCR_STAT_OFFS);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  // Uses next values so a read right after a write
  // or a capture sees the updated contents.
  always_comb begin
    rdData = `DCR_WORD_ZERO;
    if (capsHit) begin
      // Hardwired and reserved bits come out as zero
      rdData = packCaps(caps_nxt);
    end else if (ctrlHit) begin
      rdData[`DCR_CTRL_CAPEN_BIT] = capEn_nxt;
    end else if (statHit) begin
      // Shows events taken in this same cycle
      rdData[`DCR_STAT_SB_BIT]  = stat_nxt[`DCR_STAT_SB_BIT];
      rdData[`DCR_STAT_MSG_BIT] = stat_nxt[`DCR_STAT_MSG_BIT];
    end else begin
      // Unmapped offsets read zero
      rdData = `DCR_WORD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capability word output next value
  always_comb begin
    // Tracks the field register each cycle
    // Loads at the same edge as the fields, so the word and
    // a register read always agree
    capsWord_nxt = packCaps(caps_nxt);
  end

  // Capability word output register
  // Reset image matches the field reset image
  always_ff @(posedge core_clk) begin
    if (reset) begin
      capsWord_r <= packCaps(resetCaps());
    end else begin
      capsWord_r <= capsWord_nxt;
    end
  end

  // Straight from the flop
  assign capsWord = capsWord_r;

endmodule // dcr_device_caps

// ===== core/dcr_pkg.sv
package dcr_pkg;

  // One bus or register word
  typedef logic [31:0] dcr_word_t;

  // Byte address of a register
  typedef logic [11:0] dcr_addr_t;

  // Configurable capability fields
  typedef struct packed {
    logic [2:0] payload;    // Largest payload code
    logic [2:0] l0sLat;     // L0s exit latency
    logic [2:0] l1Lat;      // L1 exit latency
    logic       roleErr;    // Role-based error reporting
    logic [7:0] slotValue;  // Captured power limit value
    logic [1:0] slotScale;  // Captured power limit scale
  } dcr_caps_s;

endpackage

// ===== verification/dcr_device_caps_asserts.sv
`timescale 1ns/1ps
module dcr_device_caps_asserts (
  // Clock and reset
  input logic               core_clk,
  input logic               reset,
  // Register bus
  input logic               hsel,
  input dcr_pkg::dcr_addr_t haddr,
  input logic [1:0]         htrans,
  input logic               hwrite,
  input logic [2:0]         hsize,
  input dcr_pkg::dcr_word_t hwdata,
  input logic               hready,
  input logic               hreadyout,
  input logic               hresp,
  input dcr_pkg::dcr_word_t hrdata,
  // Sideband, message and word
  input logic               sbLoad,
  input dcr_pkg::dcr_word_t sbWord,
  input logic               splMsgValid,
  input logic [7:0]         splMsgValue,
  input logic [1:0]         splMsgScale,
  input dcr_pkg::dcr_word_t capsWord
);
  import dcr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Mirror of the capture enable, kept from word writes to control
  logic wrCtl_r;    // Control write in its data phase
  logic capEnM_r;   // Capture enable as the block holds it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrCtl_r  <= 1'b0;
      capEnM_r <= 1'b1;
    end else begin
      wrCtl_r  <= hsel && htrans[1] && hready && hwrite
                  && hsize == 3'h2 && haddr[11:2] == 10'h040;
      if (wrCtl_r) begin
        capEnM_r <= hwdata[0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // First sample after reset release
  sequence s_rel;
    $fell(reset);
  endsequence
  // Capability word read taken
  sequence s_capRead;
    hsel && htrans[1] && hready && !hwrite && haddr == 12'h0E4;
  endsequence
  a_payload_reset: assert property (s_rel |-> capsWord[2:0] == 3'h1)
    else $error("payload code wrong after reset");
  a_phantom_zero: assert property (capsWord[4:3] == 2'h0)
    else $error("phantom field not zero");
  a_unimpl_zero: assert property (!capsWord[5] && capsWord[14:12] == 3'h0)
    else $error("unimplemented bits not zero");
  a_latency_reset: assert property (s_rel |-> capsWord[11:6] == 6'h00)
    else $error("latency fields wrong after reset");
  a_roleerr_reset: assert property (s_rel |-> capsWord[15])
    else $error("role error bit low after reset");
  a_slot_value: assert property (splMsgValid && capEnM_r |=>
    capsWord[25:18] == $past(splMsgValue))
    else $error("slot value not captured");
  a_slot_scale: assert property (splMsgValid && capEnM_r |=>
    capsWord[27:26] == $past(splMsgScale))
    else $error("slot scale not captured");
  a_sideband_load: assert property (sbLoad
    && !(splMsgValid && capEnM_r) |=>
    capsWord == ($past(sbWord) & 32'h0FFC_8FC7))
    else $error("sideband load wrong");
  a_caps_hold: assert property (!sbLoad
    && !(splMsgValid && capEnM_r) |=>
    $stable(capsWord)) else $error("capability word changed");
  a_resv_zero: assert property (capsWord[17:16] == 2'h0
    && capsWord[31:28] == 4'h0) else $error("reserved bits not zero");
  a_cap_read: assert property (s_capRead |=> hrdata == capsWord)
    else $error("read data differs from word");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
endmodule // dcr_device_caps_asserts

bind dcr_device_caps dcr_device_caps_asserts u_chk (.*);

// ===== verification/dcr_device_caps_tb.sv
`timescale 1ns/1ps
module dcr_device_caps_tb;
  import dcr_pkg::*;
  // Bench drive and observe
  logic       core_clk = 1'b0;
  logic       reset    = 1'b1;
  logic       hsel     = 1'b0;
  logic [1:0] htrans   = 2'h0;
  logic       hwrite   = 1'b0;
  logic [2:0] hsize    = 3'h2;
  logic       sbLoad   = 1'b0;
  dcr_addr_t  haddr    = 12'h000;
  dcr_word_t  hwdata   = 32'h0000_0000;
  dcr_word_t  sbWord   = 32'h0000_0000;
  logic       hreadyout, hresp, splMsgValid;
  logic [7:0] splMsgValue;
  logic [1:0] splMsgScale;
  dcr_word_t  hrdata, capsWord, q;
  int         err_total = 0;
  int         checks    = 0;
  int         cyc       = 0;
  always #4 core_clk = ~core_clk;
  dcr_device_caps u_dcr_device_caps (.core_clk(core_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sbLoad(sbLoad), .sbWord(sbWord), .splMsgValid(splMsgValid),
    .splMsgValue(splMsgValue), .splMsgScale(splMsgScale),
    .capsWord(capsWord));
  dcr_upstream_model u_dcr_upstream_model (.core_clk(core_clk),
    .splMsgValid(splMsgValid), .splMsgValue(splMsgValue),
    .splMsgScale(splMsgScale));
  ////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input dcr_word_t got, input dcr_word_t exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One AHB single word transfer, result in q
  task automatic xfer(input logic w, input dcr_addr_t a, input dcr_word_t d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input dcr_addr_t a, input dcr_word_t exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  // Expected word with given slot power fields
  function automatic dcr_word_t capExp(logic [7:0] v, logic [1:0] s);
    return {4'h0, s, v, 2'h0, 16'h8001};
  endfunction
  task automatic conclude;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(12'h0E4, 32'h0000_8001);
    chk(capsWord, 32'h0000_8001);
    xfer(1'b1, 12'h0E4, 32'hFFFF_FFFF);
    rd(12'h0E4, 32'h0000_8001);
    rd(12'h010, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      u_dcr_upstream_model.sendLimit(8'hA5 ^ i[7:0], i[1:0]);
      rd(12'h0E4, capExp(8'hA5 ^ i[7:0], i[1:0]));
    end
    rd(12'h104, 32'h0000_0002);
    xfer(1'b1, 12'h104, 32'h0000_0003);
    rd(12'h104, 32'h0000_0000);
    // Capture disabled: message ignored
    xfer(1'b1, 12'h100, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    u_dcr_upstream_model.sendLimit(8'h3C, 2'h2);
    rd(12'h0E4, capExp(8'hA6, 2'h3));
    rd(12'h104, 32'h0000_0000);
    xfer(1'b1, 12'h100, 32'h0000_0001);
    // Non-word write is dropped
    hsize <= 3'h0;
    xfer(1'b1, 12'h100, 32'h0000_0000);
    hsize <= 3'h2;
    rd(12'h100, 32'h0000_0001);
    // Sideband load, then load together with a message
    sbWord <= 32'hFFFF_FFFF;
    sbLoad <= 1'b1;
    @(posedge core_clk);
    sbLoad <= 1'b0;
    rd(12'h0E4, 32'h0FFC_8FC7);
    sbWord <= 32'h0000_0000;
    sbLoad <= 1'b1;
    u_dcr_upstream_model.sendLimit(8'h5A, 2'h1);
    sbLoad <= 1'b0;
    rd(12'h0E4, {4'h0, 2'h1, 8'h5A, 18'h00000});
    rd(12'h104, 32'h0000_0003);
    // Second reset restores defaults
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(12'h0E4, 32'h0000_8001);
    rd(12'h100, 32'h0000_0001);
    rd(12'h104, 32'h0000_0000);
    conclude();
  end
endmodule // dcr_device_caps_tb

// ===== verification/dcr_upstream_model.sv
`timescale 1ns/1ps
module dcr_upstream_model (
  // Clock
  input  logic       core_clk,
  // Power limit message
  output logic       splMsgValid,
  output logic [7:0] splMsgValue,
  output logic [1:0] splMsgScale
);
  // Idle until the first message
  initial begin
    splMsgValid = 1'b0;
    splMsgValue = 8'h00;
    splMsgScale = 2'h0;
  end
  // One-cycle message, then lines scrambled so stale data is never reused
  task automatic sendLimit(input logic [7:0] v, input logic [1:0] s);
    splMsgValid <= 1'b1;
    splMsgValue <= v;
    splMsgScale <= s;
    @(posedge core_clk);
    splMsgValid <= 1'b0;
    splMsgValue <= ~v;
    splMsgScale <= ~s;
  endtask
endmodule // dcr_upstream_model
